// [include/dpt_pkg.sv]
`default_nettype none
package dpt_pkg;
  localparam logic [9:0]  ADDR_PERIOD  = 10'h0CE;
  localparam logic [9:0]  ADDR_CAPTURE = 10'h0CF;
  localparam logic [9:0]  ADDR_SYNC    = 10'h0D0;
  localparam logic [9:0]  ADDR_CLEAR   = 10'h1FA;
  localparam logic [15:0] PERIOD_RST   = 16'h0384;
  localparam logic [15:0] PERIOD_MIN   = 16'h012C;
  localparam logic [15:0] PERIOD_MAX   = 16'h0E10;
  localparam logic [15:0] CAP_RST      = 16'h000A;
  localparam logic [15:0] CAP_MIN      = 16'h0001;
  localparam logic [15:0] CAP_MAX      = 16'h0014;
  localparam logic [15:0] SYNC_INT     = 16'h0000;
  localparam logic [15:0] SYNC_MAX     = 16'h0002;
  localparam logic [15:0] CLEAR_GO     = 16'h0001;
  localparam int          CLK_HZ       = 50000000;
  localparam int          TICK_S       = 1;
  localparam int          SEC_CYC_DEF  = CLK_HZ * TICK_S;
  localparam logic [11:0] HOUR_LAST    = 12'hE0F;
  localparam int          NQ  = 15;
  localparam int          NR  = 3;
  localparam int          SW  = 16;
  localparam int          VW  = 18;
  localparam int          AW  = 30;
  localparam int          CW  = 12;
  localparam int          TW  = 32;
  localparam logic [4:0]  DIV_LAST  = 5'h1D;
  localparam int          Q_CUR     = 0;
  localparam int          Q_POS     = 3;
  localparam int          Q_POS_TOT = 6;
  localparam int          Q_NEG     = 7;
  localparam int          Q_NEG_TOT = 10;
  localparam int          Q_APP     = 11;
  localparam int          Q_APP_TOT = 14;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_INS  = 2'b11
  } dpt_st_t;

  typedef struct packed {
    logic [15:0]                    period_len;
    logic [15:0]                    cap_time;
    logic [15:0]                    sync_sel;
    logic [15:0]                    clr;
    logic [15:0]                    rdata;
    logic                           din_s1;
    logic                           din_s2;
    logic                           din_s3;
    logic [25:0]                    tick_cnt;
    logic [TW-1:0]                  sec_cnt;
    logic [11:0]                    hour_cnt;
    logic [11:0]                    elap;
    logic [NQ-1:0][AW-1:0]          acc;
    logic [CW-1:0]                  cnt;
    logic [NQ-1:0][AW-1:0]          snap;
    logic [CW-1:0]                  scnt;
    logic [TW-1:0]                  sstamp;
    dpt_st_t                        st;
    logic [3:0]                     q;
    logic [4:0]                     bitn;
    logic [AW-1:0]                  dvd;
    logic [CW:0]                    rem;
    logic [AW-1:0]                  quo;
    logic [NQ-1:0][NR-1:0][VW-1:0]  pk_mean;
    logic [NQ-1:0][NR-1:0][TW-1:0]  pk_stamp;
    logic [VW-1:0]                  rd_mean;
    logic [TW-1:0]                  rd_stamp;
    logic                           pend;
  } dpt_regs_t;

  localparam dpt_regs_t REGS_RST = '{period_len: PERIOD_RST, cap_time: CAP_RST,
                                     st: ST_IDLE, default: '0};
endpackage : dpt_pkg
`default_nettype wire

// [rtl/dpt_tracker.sv]
// Summary of operation
// - Each tracked quantity is averaged per period; the largest period means are kept.
// - Period length is settable 300 to 3600 s, 900 s after reset.
// - Periods end on internal seconds, the full hour, or digital input 1 pulses.
// - Sync source code 0 is internal, nonzero is external; default 0.
// - Fifteen quantities each keep three highest means with time stamps.
// - Quantities are phase currents, active and apparent power per phase and total.
// - Signed values split into consumption and export streams before averaging.
// - The active total sums signed phase values first, then splits into positive and negative.
// - Writing 1 to the clear register erases all stored maxima.
`timescale 1ns/100ps
`default_nettype none
module dpt_tracker
  import dpt_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYC_DEF
) (
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 ce_i,
  input  wire logic [9:0]           par_addr_i,
  input  wire logic                 par_wr_i,
  input  wire logic [15:0]          par_wdata_i,
  output logic      [15:0]          par_rdata_o,
  input  wire logic                 sample_valid_i,
  input  wire logic [2:0][SW-1:0]   cur_i,
  input  wire logic [2:0][SW-1:0]   act_i,
  input  wire logic [2:0][SW-1:0]   app_i,
  input  wire logic                 din1_i,
  input  wire logic [3:0]           peak_q_i,
  input  wire logic [1:0]           peak_rank_i,
  output logic      [VW-1:0]        peak_mean_o,
  output logic      [TW-1:0]        peak_stamp_o,
  output logic                      period_end_o,
  output logic                      busy_o
);

  dpt_regs_t             s_r;
  dpt_regs_t             s_nxt;
  logic [NQ-1:0][VW-1:0] sv;
  logic signed [VW-1:0]  act_tot;
  logic [VW-1:0]         app_tot;
  logic                  tick;
  logic                  rise;
  logic                  ext;
  logic                  bound;
  logic [15:0]           elap1;
  logic [CW:0]           rem_t;
  logic [VW-1:0]         m;

  function automatic logic [VW-1:0] pos_part(input logic signed [VW-1:0] v);
    return v[VW-1] ? '0 : v;
  endfunction : pos_part

  function automatic logic [VW-1:0] neg_part(input logic signed [VW-1:0] v);
    return v[VW-1] ? VW'(-v) : '0;
  endfunction : neg_part

  function automatic logic signed [VW-1:0] sx(input logic [SW-1:0] v);
    return {{(VW-SW){v[SW-1]}}, v};
  endfunction : sx

  // Stream map of the fifteen tracked quantities
  always_comb begin
    act_tot = sx(act_i[0]) + sx(act_i[1]) + sx(act_i[2]);
    app_tot = VW'(app_i[0]) + VW'(app_i[1]) + VW'(app_i[2]);
    for (int p = 0; p < 3; p++) begin
      sv[Q_CUR + p] = VW'(cur_i[p]);
      sv[Q_POS + p] = pos_part(sx(act_i[p]));
      sv[Q_NEG + p] = neg_part(sx(act_i[p]));
      sv[Q_APP + p] = VW'(app_i[p]);
    end
    sv[Q_POS_TOT] = pos_part(act_tot);
    sv[Q_NEG_TOT] = neg_part(act_tot);
    sv[Q_APP_TOT] = app_tot;
  end

  assign tick  = s_r.tick_cnt == 26'(SEC_CYC - 1);
  assign rise  = s_r.din_s2 & ~s_r.din_s3;
  assign ext   = s_r.sync_sel != SYNC_INT;
  assign elap1 = {4'h0, s_r.elap} + 16'h0001;
  // External mode falls back to a forced end if no pulse within capture time
  assign bound = ext ? (rise | (tick & (elap1 >= s_r.period_len + s_r.cap_time)))
                     : (tick & ((elap1 >= s_r.period_len)
                                | (s_r.hour_cnt == HOUR_LAST)));
  assign rem_t = {s_r.rem[CW-1:0], s_r.dvd[AW-1]};
  assign m     = s_r.quo[VW-1:0];

  always_comb begin
    s_nxt        = s_r;
    s_nxt.pend   = 1'b0;
    s_nxt.din_s1 = din1_i;
    s_nxt.din_s2 = s_r.din_s1;
    s_nxt.din_s3 = s_r.din_s2;
    s_nxt.tick_cnt = tick ? '0 : s_r.tick_cnt + 26'h0000001;
    if (tick) begin
      s_nxt.sec_cnt  = s_r.sec_cnt + 32'h00000001;
      s_nxt.hour_cnt = (s_r.hour_cnt == HOUR_LAST) ? '0 : s_r.hour_cnt + 12'h001;
      if (s_r.elap != 12'hFFF) begin
        s_nxt.elap = s_r.elap + 12'h001;
      end
    end
    if (sample_valid_i) begin
      for (int i = 0; i < NQ; i++) begin
        s_nxt.acc[i] = s_r.acc[i] + AW'(sv[i]);
      end
      if (s_r.cnt != 12'hFFF) begin
        s_nxt.cnt = s_r.cnt + 12'h001;
      end
    end
    case (s_r.st)
      ST_IDLE: begin
        if (bound) begin
          s_nxt.snap   = s_nxt.acc;
          s_nxt.scnt   = s_nxt.cnt;
          s_nxt.acc    = '0;
          s_nxt.cnt    = '0;
          s_nxt.elap   = '0;
          s_nxt.sstamp = s_r.sec_cnt;
          s_nxt.q      = '0;
          s_nxt.dvd    = s_nxt.snap[0];
          s_nxt.rem    = '0;
          s_nxt.quo    = '0;
          s_nxt.bitn   = '0;
          s_nxt.pend   = 1'b1;
          s_nxt.st     = ST_DIV;
        end
      end
      ST_DIV: begin
        // Restoring divide: period sum over sample count
        s_nxt.dvd = {s_r.dvd[AW-2:0], 1'b0};
        if (rem_t >= {1'b0, s_r.scnt}) begin
          s_nxt.rem = rem_t - {1'b0, s_r.scnt};
          s_nxt.quo = {s_r.quo[AW-2:0], 1'b1};
        end else begin
          s_nxt.rem = rem_t;
          s_nxt.quo = {s_r.quo[AW-2:0], 1'b0};
        end
        s_nxt.bitn = s_r.bitn + 5'h01;
        if (s_r.bitn == DIV_LAST) begin
          s_nxt.st = ST_INS;
        end
      end
      ST_INS: begin
        if (s_r.scnt != '0) begin
          if (m > s_r.pk_mean[s_r.q][0]) begin
            s_nxt.pk_mean[s_r.q][2]  = s_r.pk_mean[s_r.q][1];
            s_nxt.pk_stamp[s_r.q][2] = s_r.pk_stamp[s_r.q][1];
            s_nxt.pk_mean[s_r.q][1]  = s_r.pk_mean[s_r.q][0];
            s_nxt.pk_stamp[s_r.q][1] = s_r.pk_stamp[s_r.q][0];
            s_nxt.pk_mean[s_r.q][0]  = m;
            s_nxt.pk_stamp[s_r.q][0] = s_r.sstamp;
          end else if (m > s_r.pk_mean[s_r.q][1]) begin
            s_nxt.pk_mean[s_r.q][2]  = s_r.pk_mean[s_r.q][1];
            s_nxt.pk_stamp[s_r.q][2] = s_r.pk_stamp[s_r.q][1];
            s_nxt.pk_mean[s_r.q][1]  = m;
            s_nxt.pk_stamp[s_r.q][1] = s_r.sstamp;
          end else if (m > s_r.pk_mean[s_r.q][2]) begin
            s_nxt.pk_mean[s_r.q][2]  = m;
            s_nxt.pk_stamp[s_r.q][2] = s_r.sstamp;
          end
        end
        if (s_r.q == 4'(NQ - 1)) begin
          s_nxt.st = ST_IDLE;
        end else begin
          s_nxt.q    = s_r.q + 4'h1;
          s_nxt.dvd  = s_r.snap[s_r.q + 4'h1];
          s_nxt.rem  = '0;
          s_nxt.quo  = '0;
          s_nxt.bitn = '0;
          s_nxt.st   = ST_DIV;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    // Pending clear wipes all maxima and returns the request to 0
    if (s_r.clr == CLEAR_GO) begin
      s_nxt.pk_mean  = '0;
      s_nxt.pk_stamp = '0;
      s_nxt.clr      = '0;
    end
    // Out-of-range writes are ignored
    if (par_wr_i) begin
      case (par_addr_i)
        ADDR_PERIOD: begin
          if (par_wdata_i >= PERIOD_MIN && par_wdata_i <= PERIOD_MAX) begin
            s_nxt.period_len = par_wdata_i;
          end
        end
        ADDR_CAPTURE: begin
          if (par_wdata_i >= CAP_MIN && par_wdata_i <= CAP_MAX) begin
            s_nxt.cap_time = par_wdata_i;
          end
        end
        ADDR_SYNC: begin
          if (par_wdata_i <= SYNC_MAX) begin
            s_nxt.sync_sel = par_wdata_i;
          end
        end
        ADDR_CLEAR: begin
          if (par_wdata_i <= CLEAR_GO) begin
            s_nxt.clr = par_wdata_i;
          end
        end
        default: begin
          s_nxt.clr = s_nxt.clr;
        end
      endcase
    end
    case (par_addr_i)
      ADDR_PERIOD:  s_nxt.rdata = s_r.period_len;
      ADDR_CAPTURE: s_nxt.rdata = s_r.cap_time;
      ADDR_SYNC:    s_nxt.rdata = s_r.sync_sel;
      ADDR_CLEAR:   s_nxt.rdata = s_r.clr;
      default:      s_nxt.rdata = '0;
    endcase
    if (peak_q_i < 4'(NQ) && peak_rank_i < 2'(NR)) begin
      s_nxt.rd_mean  = s_r.pk_mean[peak_q_i][peak_rank_i];
      s_nxt.rd_stamp = s_r.pk_stamp[peak_q_i][peak_rank_i];
    end else begin
      s_nxt.rd_mean  = '0;
      s_nxt.rd_stamp = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_r <= REGS_RST;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign par_rdata_o  = s_r.rdata;
  assign peak_mean_o  = s_r.rd_mean;
  assign peak_stamp_o = s_r.rd_stamp;
  assign period_end_o = s_r.pend;
  assign busy_o       = s_r.st != ST_IDLE;

  function automatic logic sorted_ok(input logic [NQ-1:0][NR-1:0][VW-1:0] pk);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < NQ; i++) begin
      ok = ok & (pk[i][0] >= pk[i][1]) & (pk[i][1] >= pk[i][2]);
    end
    return ok;
  endfunction : sorted_ok

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_clr_wr;
    ce_i && par_wr_i && par_addr_i == ADDR_CLEAR && par_wdata_i == CLEAR_GO;
  endsequence
  sequence s_clr_done;
    ce_i [*2] ##1 (s_r.pk_mean == '0 && s_r.clr == '0);
  endsequence

  property p_clear;
    s_clr_wr |-> s_clr_done;
  endproperty
  a_clear: assert property (p_clear) else $error("maxima not cleared");

  property p_period_range;
    s_r.period_len >= PERIOD_MIN && s_r.period_len <= PERIOD_MAX;
  endproperty
  a_period_range: assert property (p_period_range) else $error("period out of range");

  property p_bad_write;
    ce_i && par_wr_i && par_addr_i == ADDR_PERIOD && par_wdata_i < PERIOD_MIN
      |=> $stable(s_r.period_len);
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("bad period accepted");

  property p_int_end;
    ce_i && !ext && s_r.st == ST_IDLE && tick && elap1 >= s_r.period_len
      |=> s_r.st == ST_DIV && s_r.elap == '0 && period_end_o;
  endproperty
  a_int_end: assert property (p_int_end) else $error("internal end missed");

  property p_ext_end;
    ce_i && ext && s_r.st == ST_IDLE && rise |=> s_r.st == ST_DIV;
  endproperty
  a_ext_end: assert property (p_ext_end) else $error("external end missed");

  property p_ext_quiet;
    ce_i && ext && s_r.st == ST_IDLE && !rise && !tick |=> s_r.st == ST_IDLE;
  endproperty
  a_ext_quiet: assert property (p_ext_quiet) else $error("spurious end");

  property p_split;
    sv[Q_POS] == '0 || sv[Q_NEG] == '0;
  endproperty
  a_split: assert property (p_split) else $error("both streams set");

  property p_total;
    $signed(sv[Q_POS_TOT]) - $signed(sv[Q_NEG_TOT]) == act_tot;
  endproperty
  a_total: assert property (p_total) else $error("total split wrong");

  property p_sorted;
    sorted_ok(s_r.pk_mean);
  endproperty
  a_sorted: assert property (p_sorted) else $error("maxima unordered");

  property p_top_insert;
    ce_i && s_r.st == ST_INS && s_r.scnt != '0 && s_r.clr == '0
      && m > s_r.pk_mean[s_r.q][0]
      |=> s_r.pk_mean[$past(s_r.q)][0] == $past(m)
          && s_r.pk_stamp[$past(s_r.q)][0] == $past(s_r.sstamp);
  endproperty
  a_top_insert: assert property (p_top_insert) else $error("peak not stored");

  property p_div_len;
    ce_i && s_r.st == ST_IDLE && bound ##1 ce_i [*8] |-> s_r.st == ST_DIV;
  endproperty
  a_div_len: assert property (p_div_len) else $error("divide ended early");

endmodule : dpt_tracker
`default_nettype wire

// [sim/dpt_meter_model.sv]
`timescale 1ns/100ps
`default_nettype none
module dpt_meter_model
  import dpt_pkg::*;
#(
  parameter int SEC_CYC = 20
) (
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  input  wire logic [2:0][SW-1:0] cur_set_i,
  input  wire logic [2:0][SW-1:0] act_set_i,
  input  wire logic [2:0][SW-1:0] app_set_i,
  input  wire logic               pulse_i,
  output logic                    sample_valid_o,
  output logic      [2:0][SW-1:0] cur_o,
  output logic      [2:0][SW-1:0] act_o,
  output logic      [2:0][SW-1:0] app_o,
  output logic                    din1_o
);
  int         cnt_r;
  logic [3:0] pw_r;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_r <= 0;
      pw_r  <= 4'h0;
    end else begin
      cnt_r <= (cnt_r == SEC_CYC - 1) ? 0 : cnt_r + 1;
      pw_r  <= pulse_i ? 4'hF : ((pw_r != 4'h0) ? pw_r - 4'h1 : 4'h0);
    end
  end
  // Half a second off the tick, so no sample lands on a boundary
  assign sample_valid_o = resetn_i && (cnt_r == SEC_CYC / 2);
  // Unqualified lines carry junk, never the last value
  assign cur_o  = sample_valid_o ? cur_set_i : ~cur_set_i;
  assign act_o  = sample_valid_o ? act_set_i : ~act_set_i;
  assign app_o  = sample_valid_o ? app_set_i : ~app_set_i;
  // Sync pulse on digital input 1
  assign din1_o = (pw_r != 4'h0);
endmodule : dpt_meter_model
`default_nettype wire

// [sim/dpt_tracker_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module dpt_tracker_bench
  import dpt_pkg::*;
;
  localparam int SC = 20;
  typedef struct {string nm; logic [1:0] src; logic [31:0] v;} dpt_exp_t;
  logic                clk_i, resetn_i, ce_i, par_wr_i, look, pulse;
  logic                sample_valid_i, din1_i, period_end_o, busy_o;
  logic [9:0]          par_addr_i;
  logic [15:0]         par_wdata_i, par_rdata_o, v1, v2, v3;
  logic [2:0][SW-1:0]  cur_i, act_i, app_i, cur_s, act_s, app_s;
  logic [3:0]          peak_q_i;
  logic [1:0]          peak_rank_i;
  logic [VW-1:0]       peak_mean_o;
  logic [TW-1:0]       peak_stamp_o;
  int                  err_count, cmp_count, seed;
  dpt_exp_t            expq[$];
  dpt_exp_t            e;

  dpt_tracker #(.SEC_CYC(SC)) dpt_tracker_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .par_addr_i(par_addr_i),
    .par_wr_i(par_wr_i), .par_wdata_i(par_wdata_i), .par_rdata_o(par_rdata_o),
    .sample_valid_i(sample_valid_i), .cur_i(cur_i), .act_i(act_i), .app_i(app_i),
    .din1_i(din1_i), .peak_q_i(peak_q_i), .peak_rank_i(peak_rank_i),
    .peak_mean_o(peak_mean_o), .peak_stamp_o(peak_stamp_o),
    .period_end_o(period_end_o), .busy_o(busy_o));

  dpt_meter_model #(.SEC_CYC(SC)) dpt_meter_model_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .cur_set_i(cur_s), .act_set_i(act_s),
    .app_set_i(app_s), .pulse_i(pulse), .sample_valid_o(sample_valid_i),
    .cur_o(cur_i), .act_o(act_i), .app_o(app_i), .din1_o(din1_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  always @(posedge clk_i) begin
    if (look) begin
      e = expq.pop_front();
      case (e.src)
        2'h0:    chk(e.nm, {16'h0000, par_rdata_o}, e.v);
        2'h1:    chk(e.nm, {14'h0000, peak_mean_o}, e.v);
        default: chk(e.nm, peak_stamp_o, e.v);
      endcase
    end
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic rd(input logic [1:0] src, input logic [9:0] a, input logic [31:0] v,
                    input string nm);
    @(posedge clk_i);
    if (src == 2'h0) par_addr_i <= a;
    else {peak_q_i, peak_rank_i} <= a[5:0];
    expq.push_back('{nm, src, v});
    @(posedge clk_i);
    look <= 1'b1;
    @(posedge clk_i);
    look <= 1'b0;
  endtask : rd

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk_i);
    par_addr_i  <= a;
    par_wdata_i <= d;
    par_wr_i    <= 1'b1;
    @(posedge clk_i);
    par_wr_i    <= 1'b0;
  endtask : wr

  // Signed phase values; the total is negative for every chosen v
  task automatic setv(input logic [15:0] v);
    @(posedge clk_i);
    cur_s <= {v + 16'h0002, v + 16'h0001, v};
    act_s <= {16'h0010, 16'h0000 - (v << 1), v};
    app_s <= {v + 16'h0005, v + 16'h0004, v + 16'h0003};
  endtask : setv

  task automatic wait_pe(input int lim, input logic [15:0] nv);
    int n;
    n = 0;
    while (period_end_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("period_end", {31'h0, period_end_o}, 32'h1);
    setv(nv);
    n = 0;
    while (busy_o !== 1'b0 && n < 1000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    // One busy cycle is spent by setv before counting starts
    chk("busy_len", 32'(n), 32'(NQ * (DIV_LAST + 2) - 1));
  endtask : wait_pe

  function automatic logic [31:0] em(input int q, input logic [15:0] v);
    logic [31:0] w;
    w = {16'h0000, v};
    case (q)
      0, 1, 2:    em = w + 32'(q);
      3:          em = w;
      5:          em = 32'h10;
      8:          em = w << 1;
      10:         em = w - 32'h10;
      11, 12, 13: em = w + 32'(q - 8);
      14:         em = 32'h3 * w + 32'hC;
      default:    em = 32'h0;
    endcase
  endfunction : em

  task automatic pk(input int q, input int r, input logic [31:0] m, input logic [31:0] s);
    rd(2'h1, {4'h0, 4'(q), 2'(r)}, m, "peak_mean");
    rd(2'h2, {4'h0, 4'(q), 2'(r)}, s, "peak_stamp");
  endtask : pk

  initial begin
    seed = 43367;
    {resetn_i, par_wr_i, look, pulse} = 4'h0;
    ce_i = 1'b1;
    par_addr_i = 10'h000;
    par_wdata_i = 16'h0000;
    {peak_q_i, peak_rank_i} = 6'h00;
    cur_s = '0;
    act_s = '0;
    app_s = '0;
    v1 = 16'h0100 + (16'($random(seed)) & 16'h0FFF);
    v2 = v1 + 16'h1000;
    v3 = v1 + 16'h0800;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    setv(v1);
    rd(2'h0, ADDR_PERIOD, PERIOD_RST, "period_rst");
    rd(2'h0, ADDR_CAPTURE, CAP_RST, "capture_rst");
    rd(2'h0, ADDR_SYNC, SYNC_INT, "sync_rst");
    rd(2'h0, ADDR_CLEAR, 32'h0, "clear_rst");
    rd(2'h0, 10'h0D1, 32'h0, "unmapped");
    wr(ADDR_PERIOD, PERIOD_MIN - 16'h0001);
    rd(2'h0, ADDR_PERIOD, PERIOD_RST, "period_low");
    wr(ADDR_PERIOD, PERIOD_MAX + 16'h0001);
    rd(2'h0, ADDR_PERIOD, PERIOD_RST, "period_high");
    wr(ADDR_PERIOD, PERIOD_MAX);
    rd(2'h0, ADDR_PERIOD, PERIOD_MAX, "period_max");
    wr(ADDR_SYNC, SYNC_MAX + 16'h0001);
    rd(2'h0, ADDR_SYNC, SYNC_INT, "sync_bad");
    wr(ADDR_PERIOD, PERIOD_MIN);
    rd(2'h0, ADDR_PERIOD, PERIOD_MIN, "period_min");
    $display("test registers done");
    wait_pe(8000, v2);
    // Zero means never beat an empty slot, so their stamp stays 0
    for (int q = 0; q < NQ; q++) begin
      pk(q, 0, em(q, v1), (em(q, v1) != 32'h0) ? 32'd299 : 32'd0);
    end
    $display("test first period done");
    wait_pe(8000, v3);
    pk(0, 0, em(0, v2), 32'd599);
    pk(0, 1, em(0, v1), 32'd299);
    wait_pe(8000, v3);
    pk(0, 0, em(0, v2), 32'd599);
    pk(0, 1, em(0, v3), 32'd899);
    pk(0, 2, em(0, v1), 32'd299);
    $display("test ranking done");
    wr(ADDR_CLEAR, CLEAR_GO);
    for (int r = 0; r < NR; r++) pk(14, r, 32'h0, 32'h0);
    pk(0, 0, 32'h0, 32'h0);
    rd(2'h0, ADDR_CLEAR, 32'h0, "clear_back");
    $display("test clear done");
    // Write while disabled must be lost
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(ADDR_PERIOD, 16'h0258);
    ce_i <= 1'b1;
    rd(2'h0, ADDR_PERIOD, PERIOD_MIN, "period_frozen");
    $display("test clock enable done");
    wr(ADDR_CAPTURE, 16'h0005);
    for (int c = 1; c <= 2; c++) begin
      wr(ADDR_SYNC, 16'(c));
      rd(2'h0, ADDR_SYNC, 32'(c), "sync_ext");
      @(posedge clk_i);
      pulse <= 1'b1;
      @(posedge clk_i);
      pulse <= 1'b0;
      wait_pe(12, v1);
    end
    $display("test external sync done");
    repeat (4) @(posedge clk_i);
    complete_run();
  end

  initial begin
    #1000000;
    err_count++;
    complete_run();
  end
endmodule : dpt_tracker_bench
`default_nettype wire
